/* design/pd_odt_ctrl.sv */
// power-down entry/exit and synchronous on-die termination control of the memory device
//
// Operation
// - CKE registered low with nop or deselect enters power-down.
// - Row, precharge or refresh in flight completes before low-power state.
// - All banks closed gives precharge power-down, otherwise active power-down.
// - Entry disables buffers, command receivers off after tCPDED; controller sends nops.
// - Precharge power-down with fast-exit bit clear turns DLL off; otherwise DLL stays.
// - Reset asserted during power-down leaves power-down for reset state.
// - CKE registered high with nop or deselect exits; commands after tXP/tXPDLL.
// - Termination applies to data lanes via ODT pin; off in self-refresh.
// - Termination only when nominal or write termination bits nonzero.
// - Termination on/off decided from ODT pin and mode bits, no command decode.
// - Synchronous termination timing whenever the DLL is on and locked.
// - Termination follows sampled ODT after write latency minus two cycles.
// - Internal ODT also delayed by additive latency: CWL plus AL minus two.
// - ODT low around reads; device terminates again once it stops driving.
`timescale 1ns/1ns
module pd_odt_ctrl
	import pd_odt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// memory command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic a10,
	input wire logic odt,
	// read datapath is driving the data lanes (same clock)
	input wire logic dq_driving,
	// block outputs
	output logic rtt_en,
	output logic dll_en,
	output logic io_buf_en,
	output logic cmd_rx_en,
	output logic low_power
);

	// cke, four command lines, three bank bits, a10 and odt
	localparam int PIN_W = 10;

	// pin synchroniser: first stage is read only by the second stage
	logic [PIN_W-1:0] pin_meta_q;
	logic [PIN_W-1:0] pin_q;
	logic [PIN_W-1:0] pin_raw;

	assign pin_raw = {cke, cs_n, ras_n, cas_n, we_n, ba, a10, odt};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_meta_q <= '0;
			pin_q <= '0;
		end
		else
		begin
			pin_meta_q <= pin_raw;
			pin_q <= pin_meta_q;
		end
	end

	logic cke_s;
	logic [3:0] cmd_s;
	logic [2:0] ba_s;
	logic a10_s;
	logic odt_s;

	assign cke_s = pin_q[9];
	assign cmd_s = pin_q[8:5];
	assign ba_s = pin_q[4:2];
	assign a10_s = pin_q[1];
	assign odt_s = pin_q[0];

	// registers and state
	logic [31:0] ctrl_q;
	pd_state_t state_q;
	pd_state_t state_d;
	logic cke_prev_q;
	logic [3:0] busy_q;
	logic [3:0] busy_d;
	logic [3:0] cpded_q;
	logic [3:0] cpded_d;
	logic rtt_q;
	logic rtt_d;
	logic dll_q;
	logic dll_d;
	logic buf_q;
	logic buf_d;
	logic cmdrx_q;
	logic cmdrx_d;
	logic lowp_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [7:0] banks_open;

	// control fields
	logic fast_exit;
	logic [3:0] cwl;
	logic [3:0] al;
	logic [2:0] rtt_nom;
	logic [1:0] rtt_wr;
	logic self_refresh;

	assign fast_exit = ctrl_q[CTRL_FAST_EXIT_BIT];
	assign cwl = ctrl_q[CTRL_CWL_LSB +: 4];
	assign al = ctrl_q[CTRL_AL_LSB +: 4];
	assign rtt_nom = ctrl_q[CTRL_RTT_NOM_LSB +: 3];
	assign rtt_wr = ctrl_q[CTRL_RTT_WR_LSB +: 2];
	assign self_refresh = ctrl_q[CTRL_SELF_REFRESH_BIT];

	// command qualification: once receivers are off, command pins only count for the idle check on exit
	logic cmd_valid;
	logic idle_cmd;
	logic op_start;
	logic pd_entry;
	logic pd_exit;
	logic in_pd;

	assign cmd_valid = cke_s && cmdrx_q;
	assign idle_cmd = is_idle_cmd(cmd_s);
	assign op_start = cmd_valid && ((cmd_s == CMD_ACT) || (cmd_s == CMD_PRE)
		|| (cmd_s == CMD_REF));
	assign pd_entry = (state_q == PD_RUN) && cke_prev_q && !cke_s && idle_cmd;
	assign in_pd = (state_q != PD_RUN);
	assign pd_exit = in_pd && cke_s && is_idle_cmd(cmd_s);

	bank_tracker u_banks (
		.clk(pclk),
		.rst_n(presetn),
		.cmd_valid(cmd_valid),
		.cmd(cmd_s),
		.ba(ba_s),
		.a10(a10_s),
		.open_q(banks_open)
	);

	// in-flight row/precharge/refresh timer keeps counting after cke drops
	assign busy_d = op_start ? BUSY_LOAD : ((busy_q != 4'h0) ? busy_q - 4'h1 : 4'h0);

	// power-down state machine
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			PD_RUN:
				if (pd_entry)
					state_d = PD_ENTERING;
			PD_ENTERING:
				if (pd_exit)
					state_d = PD_RUN;
				else if (busy_q == 4'h0)
					state_d = (banks_open != 8'h00) ? PD_ACTIVE : PD_PRECHARGE;
			PD_ACTIVE, PD_PRECHARGE:
				if (pd_exit)
					state_d = PD_RUN;
		endcase
	end

	// receivers stay on for tCPDED after entry so trailing nops still land
	assign cpded_d = pd_entry ? TCPDED_LOAD
		: ((cpded_q != 4'h0) ? cpded_q - 4'h1 : 4'h0);
	assign buf_d = (state_d == PD_RUN);
	assign cmdrx_d = (state_d == PD_RUN) || (cpded_d != 4'h0);

	// dll frozen only in slow-exit precharge power-down
	assign dll_d = !((state_d == PD_PRECHARGE) && !fast_exit);

	// termination: latency = cwl + al - 2, clamped at zero
	logic [ODT_LAT_W:0] lat_sum;
	logic [ODT_LAT_W-1:0] odt_lat;
	logic odt_late;
	logic odt_mode_en;
	logic sync_mode;

	assign lat_sum = {2'b00, cwl} + {2'b00, al};
	assign odt_lat = (lat_sum < 6'd2) ? '0 : ODT_LAT_W'(lat_sum - 6'd2);

	odt_delay_line u_odt_line (
		.clk(pclk),
		.rst_n(presetn),
		.odt_in(odt_s),
		.lat(odt_lat),
		.odt_out(odt_late)
	);

	assign odt_mode_en = (rtt_nom != 3'b000) || (rtt_wr != 2'b00);
	assign sync_mode = dll_q;
	// only the pin, the mode bits, the dll state and the read driver decide; commands are not decoded
	assign rtt_d = sync_mode && odt_mode_en && !self_refresh && odt_late
		&& !dq_driving;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= PD_RUN;
			cke_prev_q <= 1'b0;
			busy_q <= 4'h0;
			cpded_q <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			cke_prev_q <= cke_s;
			busy_q <= busy_d;
			cpded_q <= cpded_d;
		end
	end

	// registered outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rtt_q <= 1'b0;
			dll_q <= 1'b1;
			buf_q <= 1'b1;
			cmdrx_q <= 1'b1;
			lowp_q <= 1'b0;
		end
		else
		begin
			rtt_q <= rtt_d;
			dll_q <= dll_d;
			buf_q <= buf_d;
			cmdrx_q <= cmdrx_d;
			lowp_q <= (state_d == PD_ACTIVE) || (state_d == PD_PRECHARGE);
		end
	end

	// apb decode; no wait state: pready rises in the first access cycle
	logic hit_ctrl;
	logic hit_stat;
	logic setup_ph;
	logic wr_en;
	logic [31:0] stat_word;
	logic [31:0] rd_word;

	assign hit_ctrl = (paddr == CTRL_OFF);
	assign hit_stat = (paddr == STATUS_OFF);
	assign setup_ph = psel && !penable;
	assign wr_en = psel && penable && pready_q && pwrite && hit_ctrl;

	assign stat_word = {3'b000, odt_lat, 7'h00, (busy_q != 4'h0), banks_open,
		cmdrx_q, buf_q, rtt_q, dll_q, 2'b00, state_q};
	assign rd_word = hit_ctrl ? ctrl_q : (hit_stat ? stat_word : 32'h0000_0000);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= CTRL_RESET;
		else if (wr_en)
			ctrl_q <= pwdata;
	end

	// answer is prepared at setup and held through the single access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= setup_ph;
			prdata_q <= (setup_ph && !pwrite) ? rd_word : 32'h0000_0000;
			pslverr_q <= setup_ph && !hit_ctrl && !hit_stat;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rtt_en = rtt_q;
	assign dll_en = dll_q;
	assign io_buf_en = buf_q;
	assign cmd_rx_en = cmdrx_q;
	assign low_power = lowp_q;

endmodule

/* design/pd_odt_pkg.sv */
// constants, types and decode helpers shared by the power-down / termination block
package pd_odt_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int OP_BUSY_NS = 60;
	localparam int OP_BUSY_CYC = (OP_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TCPDED_CYC = 1;
	localparam logic [3:0] BUSY_LOAD = 4'(OP_BUSY_CYC);
	localparam logic [3:0] TCPDED_LOAD = 4'(TCPDED_CYC);

	// termination delay line
	localparam int ODT_DEPTH = 32;
	localparam int ODT_LAT_W = 5;

	// register map (byte addresses)
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STATUS_OFF = 12'h004;

	// control register fields
	localparam int CTRL_FAST_EXIT_BIT = 0;
	localparam int CTRL_CWL_LSB = 4;
	localparam int CTRL_AL_LSB = 8;
	localparam int CTRL_RTT_NOM_LSB = 12;
	localparam int CTRL_RTT_WR_LSB = 16;
	localparam int CTRL_SELF_REFRESH_BIT = 20;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0050;

	// status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_DLL_BIT = 4;
	localparam int STAT_RTT_BIT = 5;
	localparam int STAT_BUF_BIT = 6;
	localparam int STAT_CMDRX_BIT = 7;
	localparam int STAT_BANKS_LSB = 8;
	localparam int STAT_BUSY_BIT = 16;
	localparam int STAT_LAT_LSB = 24;

	// command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;

	typedef enum logic [1:0] {PD_RUN, PD_ENTERING, PD_ACTIVE, PD_PRECHARGE} pd_state_t;

	// nop or deselect (cs_n high makes everything else don't care)
	function automatic logic is_idle_cmd(input logic [3:0] cmd);
		is_idle_cmd = cmd[3] || (cmd == CMD_NOP);
	endfunction

endpackage

/* design/odt_delay_line.sv */
// shift line that delays the sampled termination request by a programmable latency
`timescale 1ns/1ns
module odt_delay_line
	import pd_odt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic odt_in,
	input wire logic [ODT_LAT_W-1:0] lat,
	output logic odt_out
);

	logic [ODT_DEPTH-1:0] line_q;
	logic [ODT_DEPTH-1:0] line_d;

	// tap 0 is the current sample, tap n is n edges old
	assign line_d = {line_q[ODT_DEPTH-2:0], odt_in};
	assign odt_out = line_d[lat];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			line_q <= '0;
		else
			line_q <= line_d;
	end

endmodule

/* design/bank_tracker.sv */
// keeps one open flag per bank from activate and precharge commands
`timescale 1ns/1ns
module bank_tracker
	import pd_odt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd,
	input wire logic [2:0] ba,
	input wire logic a10,
	output logic [7:0] open_q
);

	logic is_act;
	logic is_pre;

	assign is_act = cmd_valid && (cmd == CMD_ACT);
	assign is_pre = cmd_valid && (cmd == CMD_PRE);

	// precharge with a10 high closes every bank at once
	genvar b;
	generate
		for (b = 0; b < 8; b++)
		begin : g_bank
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					open_q[b] <= 1'b0;
				else if (is_act && (ba == 3'(b)))
					open_q[b] <= 1'b1;
				else if (is_pre && (a10 || (ba == 3'(b))))
					open_q[b] <= 1'b0;
			end
		end
	endgenerate

endmodule

/* tb/pd_odt_assertions.sv */
// concurrent checks on the power-down and termination ports
`timescale 1ns/1ns
module pd_odt_assertions
	import pd_odt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic odt,
	input wire logic dq_driving,
	input wire logic rtt_en,
	input wire logic dll_en,
	input wire logic io_buf_en,
	input wire logic cmd_rx_en,
	input wire logic low_power
);
	logic [31:0] ctrl_q;
	logic [31:0] hist_q;
	logic [5:0] sum;
	logic [5:0] tap;
	logic idle;
	logic term_ok;

	// mirror of the control word and of past termination requests
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_q <= CTRL_RESET;
			hist_q <= '0;
		end
		else
		begin
			hist_q <= {hist_q[30:0], odt};
			if (pready && pwrite && paddr == CTRL_OFF)
				ctrl_q <= pwdata;
		end

	// tap is latency plus two sync stages; a negative latency clamps to zero
	assign sum = {2'h0, ctrl_q[7:4]} + {2'h0, ctrl_q[11:8]};
	assign tap = (sum < 6'h2) ? 6'h2 : sum;
	assign idle = cs_n || (ras_n && cas_n && we_n);
	assign term_ok = (ctrl_q[14:12] != 3'h0 || ctrl_q[17:16] != 2'h0) && !ctrl_q[20];

	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	entry_gating_a: assert property ($fell(cke) && idle && io_buf_en && !low_power
		|-> ##3 !io_buf_en && cmd_rx_en ##1 !cmd_rx_en) else $error("entry gating wrong");
	refused_entry_a: assert property ($fell(cke) && !idle && io_buf_en
		|-> ##3 io_buf_en) else $error("entry taken with a command");
	dll_slow_a: assert property ($fell(dll_en) |-> low_power && !ctrl_q[0])
		else $error("dll off outside slow exit");
	exit_restore_a: assert property ($rose(cke) && idle && low_power
		|-> ##3 io_buf_en && cmd_rx_en && dll_en && !low_power) else $error("exit wrong");
	reset_state_a: assert property ($rose(presetn)
		|-> !low_power && io_buf_en && dll_en && cmd_rx_en) else $error("reset state wrong");
	rtt_cause_a: assert property (rtt_en
		|-> hist_q[tap] && $past(term_ok) && !$past(dq_driving)) else $error("rtt without cause");
	rtt_on_a: assert property (hist_q[tap] && $past(term_ok) && !$past(dq_driving)
		&& dll_en && $past(dll_en) |-> rtt_en) else $error("rtt missing");
	apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer timing");
	unmapped_err_a: assert property (pready && paddr != CTRL_OFF && paddr != STATUS_OFF
		|-> pslverr && prdata == 32'h0) else $error("unmapped access");

	cover property (low_power && !dll_en);
	cover property (low_power && dll_en);
	cover property ($rose(rtt_en));
	cover property (pslverr);
endmodule

bind pd_odt_ctrl pd_odt_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .cke, .cs_n, .ras_n, .cas_n, .we_n, .odt, .dq_driving,
	.rtt_en, .dll_en, .io_buf_en, .cmd_rx_en, .low_power);

/* tb/mem_ctl_model.sv */
// memory controller model driving clock enable, commands and termination request
`timescale 1ns/1ns
module mem_ctl_model
	import pd_odt_pkg::*;
#(
	parameter int T_CKE = 3,
	parameter int T_XPDLL = 10
)
(
	input wire logic pclk,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] ba,
	output logic a10,
	output logic odt
);
	// idle bus; termination request low keeps dll-off states unterminated
	initial
	begin
		cke = 1'h1;
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		ba = 3'h0;
		a10 = 1'h0;
		odt = 1'h0;
	end

	// one command cycle, then deselect with the other lines inverted so nothing stale shows
	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic a);
		@(posedge pclk);
		{cs_n, ras_n, cas_n, we_n} <= c;
		ba <= b;
		a10 <= a;
		@(posedge pclk);
		{cs_n, ras_n, cas_n, we_n} <= {1'h1, ~c[2:0]};
		ba <= ~b;
		a10 <= ~a;
	endtask

	// entered only between bursts, with a locked dll
	task automatic pd_enter(input logic [3:0] c, input int hold);
		@(posedge pclk);
		cke <= 1'h0;
		{cs_n, ras_n, cas_n, we_n} <= c;
		@(posedge pclk);
		{cs_n, ras_n, cas_n, we_n} <= 4'hf;
		repeat ((hold < T_CKE) ? T_CKE : hold) @(posedge pclk);
	endtask

	// waits the longer dll exit latency whatever the mode
	task automatic pd_exit(input int n);
		@(posedge pclk);
		cke <= 1'h1;
		repeat ((n < T_XPDLL) ? T_XPDLL : n) @(posedge pclk);
	endtask

	task automatic odt_set(input logic v);
		@(posedge pclk);
		odt <= v;
	endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench: register access, power-down and termination scenarios
`timescale 1ns/1ns
module tb_top
	import pd_odt_pkg::*;
;
	logic pclk = 1'h0;
	logic presetn;
	logic psel, penable, pwrite, dq_driving;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, rtt_en, dll_en, io_buf_en, cmd_rx_en, low_power;
	logic cke, cs_n, ras_n, cas_n, we_n, a10, odt;
	logic [2:0] ba;
	logic [31:0] cfg [2] = '{32'h0000_0050, 32'h0010_1050};
	int fails = 0;
	int n_compared = 0;
	int lat;

	always #20 pclk = ~pclk;

	pd_odt_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .a10, .odt, .dq_driving,
		.rtt_en, .dll_en, .io_buf_en, .cmd_rx_en, .low_power);
	mem_ctl_model u_mc (.pclk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .a10, .odt);

	task automatic complete_run();
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1 && n++ < 50);
		if (pready !== 1'h1)
		begin
			fails++;
			$display("ERROR %0t apb answer missing", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// bounded run; a hang counts as a mismatch
	initial
	begin
		repeat (5000) @(posedge pclk);
		fails++;
		$display("ERROR %0t timeout", $time);
		complete_run();
	end

	initial
	begin
		presetn = 1'h0;
		{psel, penable, pwrite, dq_driving} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, CTRL_OFF, 32'h0);
		chk32(rd, 32'h0000_0050);
		apb(1'h1, STATUS_OFF, 32'hffff_ffff);
		apb(1'h0, STATUS_OFF, 32'h0);
		chk32(rd, 32'h0300_00d0);
		apb(1'h0, 12'h008, 32'h0);
		chk1(err, 1'h1);
		// slow precharge, fast precharge, then active power-down
		for (int i = 0; i < 3; i++)
		begin
			apb(1'h1, CTRL_OFF, 32'h0000_0050 | (i == 1));
			if (i == 2)
				u_mc.issue(CMD_ACT, 3'h5, 1'h0);
			u_mc.pd_enter((i == 1) ? CMD_NOP : 4'hf, 6);
			#1;
			chk1(low_power, 1'h1);
			chk1(io_buf_en, 1'h0);
			chk1(cmd_rx_en, 1'h0);
			chk1(dll_en, i != 0);
			apb(1'h0, STATUS_OFF, 32'h0);
			chk32(rd & 32'h3, (i == 2) ? 32'h2 : 32'h3);
			u_mc.pd_exit(12);
			#1;
			chk1(low_power, 1'h0);
			chk1(dll_en, 1'h1);
			u_mc.issue(CMD_PRE, 3'h0, 1'h1);
		end
		u_mc.pd_enter(CMD_WR, 4);
		#1;
		chk1(io_buf_en, 1'h1);
		u_mc.pd_exit(4);
		// reset while powered down
		u_mc.pd_enter(4'hf, 6);
		@(posedge pclk);
		presetn <= 1'h0;
		// cke is still low here, so only the reset can have ended power-down
		tick(1);
		chk1(low_power, 1'h0);
		chk1(io_buf_en, 1'h1);
		u_mc.pd_exit(2);
		#1;
		chk1(low_power, 1'h0);
		chk1(io_buf_en, 1'h1);
		@(posedge pclk);
		presetn <= 1'h1;
		// termination latency with additive latency 0 and 2
		for (int al = 0; al < 4; al += 2)
		begin
			apb(1'h1, CTRL_OFF, 32'h0000_1050 | (al << 8));
			lat = 3 + al;
			u_mc.odt_set(1'h1);
			tick(lat + 2);
			chk1(rtt_en, 1'h0);
			tick(1);
			chk1(rtt_en, 1'h1);
			@(posedge pclk);
			dq_driving <= 1'h1;
			tick(1);
			chk1(rtt_en, 1'h0);
			@(posedge pclk);
			dq_driving <= 1'h0;
			u_mc.odt_set(1'h0); // held high past the minimum
			tick(lat + 2);
			chk1(rtt_en, 1'h1);
			tick(1);
			chk1(rtt_en, 1'h0);
		end
		// no termination bits set, then self-refresh bit set
		for (int k = 0; k < 2; k++)
		begin
			apb(1'h1, CTRL_OFF, cfg[k]);
			u_mc.odt_set(1'h1);
			tick(10);
			chk1(rtt_en, 1'h0);
			u_mc.odt_set(1'h0);
		end
		tick(4);
		complete_run();
	end
endmodule
